/* File: hdl/dpbf_ecc_if.sv */
// signals between the memory and its check-bit codec
`timescale 1ns/1ps
interface dpbf_ecc_if;
  logic [63:0] enc_d;
  logic [7:0] enc_c;
  logic [63:0] dec_d;
  logic [7:0] dec_c;
  logic [63:0] dec_q;
  logic sbe;
  logic dbe;
  modport codec (input enc_d, dec_d, dec_c, output enc_c, dec_q, sbe, dbe);
  modport user (output enc_d, dec_d, dec_c, input enc_c, dec_q, sbe, dbe);
endinterface

/* File: hdl/dpbf_params.svh */
// register offsets, field positions and reset values of the block memory
`ifndef DPBF_PARAMS_SVH
`define DPBF_PARAMS_SVH
`define DPBF_WORDS 512
`define DPBF_ADR_CTRL 8'h00
`define DPBF_ADR_AFULL 8'h04
`define DPBF_ADR_AEMPTY 8'h08
`define DPBF_ADR_STATUS 8'h0c
`define DPBF_ADR_IRQ_STAT 8'h10
`define DPBF_ADR_IRQ_MASK 8'h14
`define DPBF_C_AW 2:0
`define DPBF_C_BW 5:3
`define DPBF_C_APOL 7:6
`define DPBF_C_BPOL 9:8
`define DPBF_C_AOREG 10
`define DPBF_C_BOREG 11
`define DPBF_C_SPLIT 12
`define DPBF_C_SDP 13
`define DPBF_C_CASEN 14
`define DPBF_C_CASPOS 15
`define DPBF_C_ECC 16
`define DPBF_C_FIFO 17
`define DPBF_C_FWFT 18
`define DPBF_C_AHALF 19
`define DPBF_C_BHALF 20
`define DPBF_CTRL_MASK 32'h001f_ffff
`define DPBF_CTRL_RST 32'h0000_002d
`define DPBF_THR_MASK 32'h0000_ffff
`define DPBF_AFULL_RST 32'h0000_0010
`define DPBF_AEMPTY_RST 32'h0000_0010
`define DPBF_EV_SBE 0
`define DPBF_EV_DBE 1
`define DPBF_EV_OVF 2
`define DPBF_EV_UNF 3
`define DPBF_DEPTH_BIT 16'h8000
`define DPBF_DEPTH_PAR 16'h1000
`endif

/* File: hdl/dpbf_pkg.sv */
// types shared by the block memory modules
package dpbf_pkg;
  typedef enum logic [2:0] {
    W1 = 3'h0, W2 = 3'h1, W4 = 3'h2, W9 = 3'h3, W18 = 3'h4, W36 = 3'h5, W72 = 3'h6
  } dpbf_width_t;
  typedef enum logic [1:0] {
    POL_READ_FIRST = 2'h0, POL_WRITE_FIRST = 2'h1, POL_NO_CHANGE = 2'h2
  } dpbf_policy_t;
endpackage

/* File: hdl/dpbf_secded.sv */
// hamming 72/64 encoder and single-correct double-detect decoder
`timescale 1ns/1ps
module dpbf_secded (
  dpbf_ecc_if.codec e
);
  logic [7:0] chk;
  logic [6:0] syn;
  logic par;
  logic [63:0] fix;

  function automatic logic [7:0] gen_check(input logic [63:0] d);
    logic [7:0] c;
    int j;
    c = 8'h00;
    j = 0;
    for (int p = 1; p < 72; p++) begin
      if ((p & (p - 1)) != 0) begin
        for (int i = 0; i < 7; i++) begin
          if (p[i]) c[i] = c[i] ^ d[j];
        end
        j++;
      end
    end
    c[7] = ^d ^ ^c[6:0];
    return c;
  endfunction

  assign e.enc_c = gen_check(e.enc_d);

  always_comb begin
    int j;
    j = 0;
    chk = gen_check(e.dec_d);
    syn = chk[6:0] ^ e.dec_c[6:0];
    par = ^e.dec_d ^ ^e.dec_c;
    fix = e.dec_d;
    for (int p = 1; p < 72; p++) begin
      if ((p & (p - 1)) != 0) begin
        if (par && syn == 7'(p)) fix[j] = ~fix[j];
        j++;
      end
    end
    e.dec_q = fix;
    e.sbe = par;
    e.dbe = (syn != 7'h00) && !par;
  end
endmodule

/* File: hdl/dpbf_top.sv */
// dual-port block memory with fifo controller, check bits and wishbone registers
// Function
// - two independent ports share only the stored array contents
// - all port inputs are captured in input registers on the clock
// - address stays registered; output holds until next enabled operation, except port b in fall-through mode
// - optional output register adds exactly one cycle of read latency
// - write output policy: old data, new data, or unchanged
// - port shapes 32Kx1 through 512x72, widths below 9 bits drop parity
// - both ports may use different shapes over the same contents
// - split into two half memories, each 16Kx1 to 512x36
// - widths above 18/36 bits only in split read/write mode
// - split read/write mode fixes one side at 32/36 or 64/72
// - two blocks cascade into 64Kx1 without extra logic
// - 64-bit words store eight hamming bits, correct single, flag double
// - codec usable alone for external 64 to 72 bit memories
// - fifo advances its own pointers and drives four flags
// - almost-full and almost-empty thresholds programmable independently
// - fifo write and read widths are always identical
// - fall-through mode shows first word before any read
// - after first word, each fall-through pop moves the output on to the following word
//
// The Wishbone interface to the registers and the address map were decided locally.
`timescale 1ns/1ps
`include "dpbf_params.svh"
module dpbf_top
  import dpbf_pkg::*;
(
  // system
  input wire logic clk_i,
  input wire logic reset_i,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic irq_o,
  // port a
  input wire logic a_en_i,
  input wire logic a_we_i,
  input wire logic [15:0] a_addr_i,
  input wire logic [71:0] a_din_i,
  output logic [71:0] a_dout_o,
  // port b
  input wire logic b_en_i,
  input wire logic b_we_i,
  input wire logic [15:0] b_addr_i,
  input wire logic [71:0] b_din_i,
  output logic [71:0] b_dout_o,
  // fifo flags and check-bit flags
  output logic full_o,
  output logic empty_o,
  output logic afull_o,
  output logic aempty_o,
  output logic sbiterr_o,
  output logic dbiterr_o,
  // standalone codec
  input wire logic [63:0] ext_enc_data_i,
  output logic [7:0] ext_enc_check_o,
  input wire logic [63:0] ext_dec_data_i,
  input wire logic [7:0] ext_dec_check_i,
  output logic [63:0] ext_dec_data_o,
  output logic ext_dec_sbe_o,
  output logic ext_dec_dbe_o
);
  logic [31:0] ctrl, afull_thr, aempty_thr;
  logic [3:0] irq_stat, irq_mask, ev, irq_clr;
  logic [7:0] wb_adr;
  logic wb_hit, wb_wr;
  logic [1:0] en_q, we_q, sel, op, act_we, rd_go, wr_show, half;
  logic [15:0] addr_q [2];
  logic [71:0] din_q [2];
  logic [71:0] dout_l [2];
  logic [71:0] dout_q [2];
  logic [63:0] data_mem [`DPBF_WORDS];
  logic [7:0] par_mem [`DPBF_WORDS];
  logic [15:0] wptr, rptr, rd_ptr, count, fdepth;
  logic sbe_q, dbe_q, push, pop;
  dpbf_width_t wc [2];
  dpbf_policy_t pol [2];
  logic split, split_read_write_mode, fifo, fwft, cas_en, ecc_act, cfg_err, sdp_ok;
  logic [2:0] maxw;
  logic [15:0] aeff [2];
  logic [21:0] dofs [2];
  logic [21:0] pofs [2];
  logic [8:0] dword [2];
  logic [8:0] pword [2];
  logic [5:0] dbit [2];
  logic [2:0] pbit [2];
  logic [63:0] dmask [2];
  logic [63:0] wdat [2];
  logic [63:0] nw [2];
  logic [63:0] dbase [2];
  logic [7:0] pmask [2];
  logic [7:0] wpar [2];
  logic [7:0] np [2];
  logic [7:0] pbase [2];
  logic [71:0] wv [2];
  logic [71:0] rv [2];

  dpbf_ecc_if eci ();
  dpbf_ecc_if exi ();

  function automatic logic [63:0] lowmask(input logic [2:0] w);
    return (w >= 3'h6) ? 64'hffff_ffff_ffff_ffff : (64'h1 << (7'h1 << w)) - 64'h1;
  endfunction

  function automatic logic [7:0] parmask(input logic [2:0] w);
    return (w < 3'h3) ? 8'h00 : 8'((9'h1 << (4'h1 << (w - 3'h3))) - 9'h1);
  endfunction

  function automatic logic [15:0] depth(input logic [2:0] w, input logic s);
    logic [15:0] d;
    d = (w < 3'h3) ? (`DPBF_DEPTH_BIT >> w) : (`DPBF_DEPTH_PAR >> (w - 3'h3));
    return s ? (d >> 1) : d;
  endfunction

  function automatic logic [15:0] incr(input logic [15:0] ptr, input logic [15:0] dep);
    return (ptr + 16'h1 == dep) ? 16'h0 : ptr + 16'h1;
  endfunction

  function automatic logic [31:0] bmerge(input logic [31:0] o, input logic [31:0] d, input logic [3:0] s);
    for (int i = 0; i < 4; i++) begin
      if (s[i]) o[8*i +: 8] = d[8*i +: 8];
    end
    return o;
  endfunction

  // configuration decode
  assign split = ctrl[`DPBF_C_SPLIT];
  assign split_read_write_mode = ctrl[`DPBF_C_SDP];
  assign fifo = ctrl[`DPBF_C_FIFO];
  assign fwft = ctrl[`DPBF_C_FWFT];
  assign cas_en = ctrl[`DPBF_C_CASEN];
  assign half = {ctrl[`DPBF_C_BHALF], ctrl[`DPBF_C_AHALF]};
  assign wc[0] = dpbf_width_t'(ctrl[`DPBF_C_AW]);
  assign wc[1] = fifo ? wc[0] : dpbf_width_t'(ctrl[`DPBF_C_BW]);
  assign pol[0] = dpbf_policy_t'(ctrl[`DPBF_C_APOL]);
  assign pol[1] = dpbf_policy_t'(ctrl[`DPBF_C_BPOL]);
  assign maxw = split ? W18 : W36;
  assign sdp_ok = split ? ((wc[0] == W36 || wc[1] == W36) && wc[0] <= W36 && wc[1] <= W36)
                        : ((wc[0] >= W36 || wc[1] >= W36) && wc[0] <= W72 && wc[1] <= W72);
  assign cfg_err = split_read_write_mode ? !sdp_ok : (wc[0] > maxw || wc[1] > maxw);
  assign ecc_act = ctrl[`DPBF_C_ECC] && split_read_write_mode && !split && wc[0] == W72 && wc[1] == W72;
  assign fdepth = depth(wc[0], split);

  // port qualification
  always_comb begin
    for (int p = 0; p < 2; p++) begin
      sel[p] = fifo || !cas_en || (addr_q[p][15] == ctrl[`DPBF_C_CASPOS]);
      op[p] = en_q[p] && sel[p] && !cfg_err;
    end
  end

  assign push = fifo && op[0] && we_q[0] && !full_o;
  assign pop = fifo && op[1] && !empty_o;
  assign rd_ptr = (fwft && pop) ? incr(rptr, fdepth) : rptr;
  assign act_we[0] = fifo ? push : (op[0] && we_q[0]);
  assign act_we[1] = !fifo && !split_read_write_mode && op[1] && we_q[1];
  assign rd_go[0] = !fifo && !split_read_write_mode && op[0] && !we_q[0];
  assign rd_go[1] = fifo ? (fwft || pop) : (op[1] && (split_read_write_mode || !we_q[1]));
  assign wr_show[0] = !fifo && !split_read_write_mode && act_we[0] && pol[0] != POL_NO_CHANGE;
  assign wr_show[1] = act_we[1] && pol[1] != POL_NO_CHANGE;

  // array addressing and write merging per port
  always_comb begin
    for (int p = 0; p < 2; p++) begin
      aeff[p] = fifo ? ((p == 0) ? wptr : rd_ptr) : addr_q[p];
      dofs[p] = 22'(aeff[p]) << wc[p];
      pofs[p] = (wc[p] < W9) ? 22'h0 : (22'(aeff[p]) << (wc[p] - 3'h3));
      dword[p] = split ? {half[p], dofs[p][13:6]} : dofs[p][14:6];
      pword[p] = split ? {half[p], pofs[p][10:3]} : pofs[p][11:3];
      dbit[p] = dofs[p][5:0];
      pbit[p] = pofs[p][2:0];
      dmask[p] = lowmask(wc[p]) << dbit[p];
      pmask[p] = parmask(wc[p]) << pbit[p];
      wv[p] = {din_q[p][71:64] & parmask(wc[p]), din_q[p][63:0] & lowmask(wc[p])};
      wdat[p] = wv[p][63:0] << dbit[p];
      wpar[p] = (ecc_act && p == 0) ? eci.enc_c : (wv[p][71:64] << pbit[p]);
      dbase[p] = data_mem[dword[p]];
      pbase[p] = par_mem[pword[p]];
      if (p == 1 && act_we[0] && dword[0] == dword[1]) dbase[p] = nw[0];
      if (p == 1 && act_we[0] && pword[0] == pword[1]) pbase[p] = np[0];
      nw[p] = (dbase[p] & ~dmask[p]) | (wdat[p] & dmask[p]);
      np[p] = (pbase[p] & ~pmask[p]) | (wpar[p] & pmask[p]);
      rv[p] = {(par_mem[pword[p]] >> pbit[p]) & parmask(wc[p]),
               (data_mem[dword[p]] >> dbit[p]) & lowmask(wc[p])};
    end
    if (ecc_act) rv[1] = {par_mem[pword[1]], eci.dec_q};
    if (fifo && fwft && push && rd_ptr == wptr) rv[1] = wv[0];
  end

  assign eci.enc_d = din_q[0][63:0];
  assign eci.dec_d = data_mem[dword[1]];
  assign eci.dec_c = par_mem[pword[1]];
  dpbf_secded u_ecc (
    .e(eci.codec)
  );

  assign exi.enc_d = ext_enc_data_i;
  assign exi.dec_d = ext_dec_data_i;
  assign exi.dec_c = ext_dec_check_i;
  dpbf_secded u_ext_ecc (
    .e(exi.codec)
  );

  // input registers
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      en_q <= 2'h0;
      we_q <= 2'h0;
    end else begin
      en_q <= {b_en_i, a_en_i};
      we_q <= {b_we_i, a_we_i};
    end
  end

  always_ff @(posedge clk_i) begin
    addr_q[0] <= a_addr_i;
    addr_q[1] <= b_addr_i;
    din_q[0] <= a_din_i;
    din_q[1] <= b_din_i;
  end

  // storage array, port b wins overlapping bits of a shared word
  always_ff @(posedge clk_i) begin
    for (int p = 0; p < 2; p++) begin
      if (act_we[p]) begin
        data_mem[dword[p]] <= nw[p];
        par_mem[pword[p]] <= np[p];
      end
    end
  end

  // output latches, held between enabled operations except port b in fall-through mode
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      dout_l[0] <= 72'h0;
      dout_l[1] <= 72'h0;
    end else begin
      for (int p = 0; p < 2; p++) begin
        if (en_q[p] && !sel[p]) dout_l[p] <= 72'h0;
        else if (rd_go[p]) dout_l[p] <= rv[p];
        else if (wr_show[p]) dout_l[p] <= (pol[p] == POL_WRITE_FIRST) ? wv[p] : rv[p];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      dout_q[0] <= 72'h0;
      dout_q[1] <= 72'h0;
    end else begin
      dout_q[0] <= dout_l[0];
      dout_q[1] <= dout_l[1];
    end
  end

  assign a_dout_o = ctrl[`DPBF_C_AOREG] ? dout_q[0] : dout_l[0];
  assign b_dout_o = ctrl[`DPBF_C_BOREG] ? dout_q[1] : dout_l[1];

  // check-bit flags of the last port b read
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      sbe_q <= 1'b0;
      dbe_q <= 1'b0;
    end else if (rd_go[1]) begin
      sbe_q <= ecc_act && eci.sbe;
      dbe_q <= ecc_act && eci.dbe;
    end
  end
  assign sbiterr_o = sbe_q;
  assign dbiterr_o = dbe_q;

  // standalone codec outputs
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      ext_enc_check_o <= 8'h00;
      ext_dec_data_o <= 64'h0;
      ext_dec_sbe_o <= 1'b0;
      ext_dec_dbe_o <= 1'b0;
    end else begin
      ext_enc_check_o <= exi.enc_c;
      ext_dec_data_o <= exi.dec_q;
      ext_dec_sbe_o <= exi.sbe;
      ext_dec_dbe_o <= exi.dbe;
    end
  end

  // fifo pointers and occupancy
  always_ff @(posedge clk_i) begin
    if (reset_i || !fifo) begin
      wptr <= 16'h0;
      rptr <= 16'h0;
      count <= 16'h0;
    end else begin
      if (push) wptr <= incr(wptr, fdepth);
      if (pop) rptr <= incr(rptr, fdepth);
      if (push && !pop) count <= count + 16'h1;
      else if (pop && !push) count <= count - 16'h1;
    end
  end

  assign full_o = fifo && count == fdepth;
  assign empty_o = !fifo || count == 16'h0;
  assign afull_o = fifo && count >= afull_thr[15:0];
  assign aempty_o = !fifo || count <= aempty_thr[15:0];

  // wishbone slave
  assign wb_adr = {wb_adr_i[7:2], 2'b00};
  assign wb_hit = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wb_wr = wb_hit && wb_we_i;

  always_ff @(posedge clk_i) begin
    if (reset_i) wb_ack_o <= 1'b0;
    else wb_ack_o <= wb_hit;
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      ctrl <= `DPBF_CTRL_RST;
      afull_thr <= `DPBF_AFULL_RST;
      aempty_thr <= `DPBF_AEMPTY_RST;
      irq_mask <= 4'h0;
    end else if (wb_wr) begin
      if (wb_adr == `DPBF_ADR_CTRL) ctrl <= bmerge(ctrl, wb_dat_i, wb_sel_i) & `DPBF_CTRL_MASK;
      else if (wb_adr == `DPBF_ADR_AFULL) afull_thr <= bmerge(afull_thr, wb_dat_i, wb_sel_i) & `DPBF_THR_MASK;
      else if (wb_adr == `DPBF_ADR_AEMPTY) aempty_thr <= bmerge(aempty_thr, wb_dat_i, wb_sel_i) & `DPBF_THR_MASK;
      else if (wb_adr == `DPBF_ADR_IRQ_MASK && wb_sel_i[0]) irq_mask <= wb_dat_i[3:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) wb_dat_o <= 32'h0;
    else if (wb_hit && !wb_we_i) begin
      if (wb_adr == `DPBF_ADR_CTRL) wb_dat_o <= ctrl;
      else if (wb_adr == `DPBF_ADR_AFULL) wb_dat_o <= afull_thr;
      else if (wb_adr == `DPBF_ADR_AEMPTY) wb_dat_o <= aempty_thr;
      else if (wb_adr == `DPBF_ADR_STATUS) wb_dat_o <= {count, 11'h0, cfg_err, aempty_o, afull_o, empty_o, full_o};
      else if (wb_adr == `DPBF_ADR_IRQ_STAT) wb_dat_o <= {28'h0, irq_stat};
      else if (wb_adr == `DPBF_ADR_IRQ_MASK) wb_dat_o <= {28'h0, irq_mask};
      else wb_dat_o <= 32'h0;
    end
  end

  // sticky events, write one to clear, set wins
  always_comb begin
    ev = 4'h0;
    ev[`DPBF_EV_SBE] = rd_go[1] && ecc_act && eci.sbe;
    ev[`DPBF_EV_DBE] = rd_go[1] && ecc_act && eci.dbe;
    ev[`DPBF_EV_OVF] = fifo && op[0] && we_q[0] && full_o;
    ev[`DPBF_EV_UNF] = fifo && op[1] && empty_o;
    irq_clr = (wb_wr && wb_adr == `DPBF_ADR_IRQ_STAT && wb_sel_i[0]) ? wb_dat_i[3:0] : 4'h0;
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) irq_stat <= 4'h0;
    else irq_stat <= (irq_stat & ~irq_clr) | ev;
  end

  assign irq_o = |(irq_stat & irq_mask);

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (reset_i);

  input_capture_a: assert property (a_en_i && a_we_i |=> en_q[0] && we_q[0] && addr_q[0] == $past(a_addr_i))
    else $error("port a inputs not captured");
  dout_hold_a: assert property (!en_q[0] |=> $stable(dout_l[0]))
    else $error("port a output changed without an operation");
  oreg_delay_a: assert property (ctrl[`DPBF_C_AOREG] && $stable(ctrl) |-> a_dout_o == $past(dout_l[0]))
    else $error("output register latency wrong");
  write_first_a: assert property (act_we[0] && !fifo && !split_read_write_mode && pol[0] == POL_WRITE_FIRST
    |=> dout_l[0][63:0] == $past(din_q[0][63:0] & lowmask(wc[0])))
    else $error("write-first output not the new word");
  no_change_a: assert property (act_we[1] && pol[1] == POL_NO_CHANGE |=> $stable(dout_l[1]))
    else $error("no-change output moved during write");
  cfg_block_a: assert property (cfg_err |-> act_we == 2'h0 && rd_go[0] == 1'b0)
    else $error("illegal shape still accessed the array");
  full_refuse_a: assert property (full_o && !pop |=> $stable(wptr) && $stable(count))
    else $error("push accepted while full");
  count_step_a: assert property (push && !pop |=> count == $past(count) + 16'h1)
    else $error("occupancy did not rise on push");
  fwft_first_a: assert property (fifo && fwft && empty_o && push
    |=> dout_l[1][63:0] == $past(din_q[0][63:0] & lowmask(wc[0])) && !empty_o)
    else $error("first word not presented in fall-through mode");
  dbe_sticky_a: assert property (ev[`DPBF_EV_DBE] |=> irq_stat[`DPBF_EV_DBE]
    ##1 (irq_stat[`DPBF_EV_DBE] || $past(irq_clr[`DPBF_EV_DBE])))
    else $error("double-bit error not latched");
endmodule

/* File: tb/dpbf_fabric_model.sv */
// fabric-side user logic driving both memory ports
`timescale 1ns/1ps
module dpbf_fabric_model (
  // system
  input wire logic clk_i,
  // fifo flags
  input wire logic full_i,
  input wire logic empty_i,
  // port a
  output logic a_en_o,
  output logic a_we_o,
  output logic [15:0] a_addr_o,
  output logic [71:0] a_din_o,
  // port b
  output logic b_en_o,
  output logic b_we_o,
  output logic [15:0] b_addr_o,
  output logic [71:0] b_din_o
);
  initial begin
    a_en_o = 1'b0;
    a_we_o = 1'b0;
    a_addr_o = 16'h0000;
    a_din_o = 72'h0;
    b_en_o = 1'b0;
    b_we_o = 1'b0;
    b_addr_o = 16'h0000;
    b_din_o = 72'h0;
  end
  // one enabled op; idle lines are inverted so stale values never match
  task automatic op(input logic pb, input logic we, input logic [15:0] adr, input logic [71:0] d);
    @(posedge clk_i);
    if (pb) begin
      b_en_o <= 1'b1;
      b_we_o <= we;
      b_addr_o <= adr;
      b_din_o <= d;
    end else begin
      a_en_o <= 1'b1;
      a_we_o <= we;
      a_addr_o <= adr;
      a_din_o <= d;
    end
    @(posedge clk_i);
    a_en_o <= 1'b0;
    b_en_o <= 1'b0;
    a_addr_o <= ~a_addr_o;
    b_addr_o <= ~b_addr_o;
    a_din_o <= ~a_din_o;
    b_din_o <= ~b_din_o;
  endtask
  // push only while room is left
  task automatic push(input logic [71:0] d);
    if (full_i !== 1'b1) op(1'b0, 1'b1, 16'h0000, d);
  endtask
  // pop only while data is held, unless a refusal is wanted
  task automatic pop(input logic anyway);
    if (empty_i !== 1'b1 || anyway) op(1'b1, 1'b0, 16'h0000, 72'h0);
  endtask
endmodule

/* File: tb/tb.sv */
// self-checking bench for the dual-port block memory
`timescale 1ns/1ps
`include "dpbf_params.svh"
module tb;
  logic clk_i, reset_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, irq_o;
  logic [7:0] wb_adr_i;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, q;
  logic a_en_i, a_we_i, b_en_i, b_we_i;
  logic [15:0] a_addr_i, b_addr_i;
  logic [71:0] a_din_i, a_dout_o, b_din_i, b_dout_o;
  logic full_o, empty_o, afull_o, aempty_o, sbiterr_o, dbiterr_o, ext_dec_sbe_o, ext_dec_dbe_o;
  logic [63:0] ext_enc_data_i, ext_dec_data_i, ext_dec_data_o;
  logic [7:0] ext_enc_check_o, ext_dec_check_i, chk;
  int errors = 0;
  int num_checks = 0;
  dpbf_top dpbf_top_inst (.clk_i(clk_i), .reset_i(reset_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .irq_o(irq_o), .a_en_i(a_en_i), .a_we_i(a_we_i), .a_addr_i(a_addr_i),
    .a_din_i(a_din_i), .a_dout_o(a_dout_o), .b_en_i(b_en_i), .b_we_i(b_we_i), .b_addr_i(b_addr_i),
    .b_din_i(b_din_i), .b_dout_o(b_dout_o), .full_o(full_o), .empty_o(empty_o), .afull_o(afull_o),
    .aempty_o(aempty_o), .sbiterr_o(sbiterr_o), .dbiterr_o(dbiterr_o), .ext_enc_data_i(ext_enc_data_i),
    .ext_enc_check_o(ext_enc_check_o), .ext_dec_data_i(ext_dec_data_i), .ext_dec_check_i(ext_dec_check_i),
    .ext_dec_data_o(ext_dec_data_o), .ext_dec_sbe_o(ext_dec_sbe_o), .ext_dec_dbe_o(ext_dec_dbe_o));
  dpbf_fabric_model fab (.clk_i(clk_i), .full_i(full_o), .empty_i(empty_o), .a_en_o(a_en_i),
    .a_we_o(a_we_i), .a_addr_o(a_addr_i), .a_din_o(a_din_i), .b_en_o(b_en_i), .b_we_o(b_we_i),
    .b_addr_o(b_addr_i), .b_din_o(b_din_i));
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  task automatic chk_v(input logic [71:0] got, input logic [71:0] exp, input string what);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic edges(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_dat_i <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    chk_v({71'h0, wb_ack_o}, 72'h1, "bus ack");
  endtask
  task automatic rd(input logic [7:0] adr, input logic [31:0] exp);
    wb(1'b0, adr, 32'h0);
    chk_v({40'h0, q}, {40'h0, exp}, "register read");
  endtask
  task automatic test_reset;
    rd(`DPBF_ADR_CTRL, `DPBF_CTRL_RST);
    rd(`DPBF_ADR_AFULL, `DPBF_AFULL_RST);
    rd(`DPBF_ADR_IRQ_MASK, 32'h0);
    rd(`DPBF_ADR_STATUS, 32'h0000_000a);
    wb(1'b1, 8'h1c, 32'hffff_ffff);
    rd(8'h1c, 32'h0);
    $display("test reset done");
  endtask
  task automatic test_shapes;
    fab.op(1'b0, 1'b1, 16'h0003, {4'h0, 4'ha, 32'h0, 32'h1234_5678});
    fab.op(1'b1, 1'b0, 16'h0003, 72'h0);
    edges(1);
    chk_v(b_dout_o, {4'h0, 4'ha, 32'h0, 32'h1234_5678}, "b reads a write");
    wb(1'b1, `DPBF_ADR_CTRL, 32'h0000_002e);
    fab.op(1'b0, 1'b1, 16'h0001, 72'h0);
    rd(`DPBF_ADR_STATUS, 32'h0000_001a);
    wb(1'b1, `DPBF_ADR_CTRL, 32'h0000_0025);
    fab.op(1'b1, 1'b0, 16'h0007, 72'h0);
    edges(1);
    chk_v(b_dout_o, {6'h0, 2'b10, 48'h0, 16'h1234}, "mixed shape");
    wb(1'b1, `DPBF_ADR_CTRL, 32'h0000_4000);
    fab.op(1'b0, 1'b0, 16'h0063, 72'h0);
    edges(1);
    chk_v(a_dout_o, 72'h1, "cascade selected");
    fab.op(1'b0, 1'b0, 16'h8063, 72'h0);
    edges(1);
    chk_v(a_dout_o, 72'h0, "cascade other block");
    wb(1'b1, `DPBF_ADR_CTRL, 32'h0000_002d);
    $display("test shapes done");
  endtask
  task automatic test_policy;
    fab.op(1'b0, 1'b1, 16'h000a, 72'h55);
    for (int p = 0; p < 3; p++) begin
      wb(1'b1, `DPBF_ADR_CTRL, 32'h0000_002d | (p << 6) | (p << 8));
      fab.op(1'b0, 1'b1, 16'h0009, 72'h100 + p);
      fab.op(1'b0, 1'b0, 16'h000a, 72'h0);
      edges(1);
      chk_v(a_dout_o, 72'h55, "read before write");
      fab.op(1'b0, 1'b1, 16'h0009, 72'h200 + p);
      edges(1);
      chk_v(a_dout_o, p == 0 ? 72'h100 + p : p == 1 ? 72'h200 + p : 72'h55, "write policy");
      fab.op(1'b1, 1'b1, 16'h0009, 72'h300 + p);
      edges(1);
      chk_v(b_dout_o, p == 0 ? 72'h200 : 72'h301, "port b write policy");
    end
    wb(1'b1, `DPBF_ADR_CTRL, 32'h0000_042d);
    fab.op(1'b0, 1'b0, 16'h000a, 72'h0);
    edges(3);
    fab.op(1'b0, 1'b0, 16'h0009, 72'h0);
    edges(0);
    chk_v(a_dout_o, 72'h55, "oreg not yet");
    edges(1);
    chk_v(a_dout_o, 72'h55, "oreg one later");
    edges(1);
    chk_v(a_dout_o, 72'h302, "oreg data");
    $display("test policy done");
  endtask
  task automatic test_fifo;
    wb(1'b1, `DPBF_ADR_CTRL, 32'h0002_002d);
    wb(1'b1, `DPBF_ADR_AFULL, 32'h3);
    wb(1'b1, `DPBF_ADR_AEMPTY, 32'h1);
    for (int i = 0; i < 3; i++) fab.push(72'h30 + i);
    edges(1);
    rd(`DPBF_ADR_STATUS, 32'h0003_0004);
    chk_v({70'h0, afull_o, aempty_o}, 72'h2, "almost flags");
    for (int i = 0; i < 3; i++) begin
      fab.pop(1'b0);
      edges(1);
      chk_v(b_dout_o, 72'h30 + i, "fifo order");
    end
    chk_v({70'h0, empty_o, aempty_o}, 72'h3, "empty flags");
    rd(`DPBF_ADR_IRQ_STAT, 32'h0);
    fab.pop(1'b1);
    edges(2);
    rd(`DPBF_ADR_IRQ_STAT, 32'h8);
    chk_v({71'h0, irq_o}, 72'h0, "masked irq");
    wb(1'b1, `DPBF_ADR_IRQ_MASK, 32'h8);
    edges(1);
    chk_v({71'h0, irq_o}, 72'h1, "irq raised");
    wb(1'b1, `DPBF_ADR_IRQ_STAT, 32'h8);
    edges(1);
    chk_v({71'h0, irq_o}, 72'h0, "irq cleared");
    wb(1'b1, `DPBF_ADR_CTRL, 32'h0006_002d);
    fab.push(72'h77);
    edges(1);
    chk_v(b_dout_o, 72'h77, "fall-through word");
    fab.pop(1'b0);
    edges(1);
    chk_v({71'h0, empty_o}, 72'h1, "empty after pop");
    wb(1'b1, `DPBF_ADR_CTRL, 32'h0002_2036);
    for (int i = 0; i < `DPBF_WORDS; i++) fab.push(72'h40 + i);
    edges(1);
    chk_v({71'h0, full_o}, 72'h1, "fifo full");
    fab.op(1'b0, 1'b1, 16'h0000, 72'h0);
    edges(2);
    rd(`DPBF_ADR_IRQ_STAT, 32'h4);
    chk_v({71'h0, full_o}, 72'h1, "full after refused push");
    $display("test fifo done");
  endtask
  task automatic test_codec;
    @(posedge clk_i);
    ext_enc_data_i <= 64'h0123_4567_89ab_cdef;
    edges(2);
    chk = ext_enc_check_o;
    for (int k = 0; k < 3; k++) begin
      @(posedge clk_i);
      ext_dec_data_i <= 64'h0123_4567_89ab_cdef ^ (k == 0 ? 64'h0 : k == 1 ? 64'h1 : 64'h3);
      ext_dec_check_i <= chk;
      edges(2);
      if (k < 2) chk_v({8'h0, ext_dec_data_o}, 72'h0123_4567_89ab_cdef, "corrected");
      chk_v({70'h0, ext_dec_sbe_o, ext_dec_dbe_o}, k == 0 ? 72'h0 : k == 1 ? 72'h2 : 72'h1, "codec flags");
    end
    for (int k = 0; k < 3; k++) begin
      wb(1'b1, `DPBF_ADR_CTRL, 32'h0001_2036);
      fab.op(1'b0, 1'b1, 16'h0005, {8'h0, 64'h0123_4567_89ab_cdef});
      wb(1'b1, `DPBF_ADR_CTRL, 32'h0000_2036);
      if (k > 0) fab.op(1'b0, 1'b1, 16'h0005, {chk, 64'h0123_4567_89ab_cdef ^ (k == 1 ? 64'h1 : 64'h3)});
      wb(1'b1, `DPBF_ADR_CTRL, 32'h0001_2036);
      fab.op(1'b1, 1'b0, 16'h0005, 72'h0);
      edges(1);
      if (k < 2) chk_v({8'h0, b_dout_o[63:0]}, {8'h0, 64'h0123_4567_89ab_cdef}, "ecc data");
      chk_v({70'h0, sbiterr_o, dbiterr_o}, k == 0 ? 72'h0 : k == 1 ? 72'h2 : 72'h1, "ecc flags");
    end
    rd(`DPBF_ADR_IRQ_STAT, 32'h7);
    $display("test codec done");
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  initial begin
    reset_i = 1'b1;
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    wb_we_i = 1'b0;
    wb_adr_i = 8'h00;
    wb_sel_i = 4'hf;
    wb_dat_i = 32'h0;
    ext_enc_data_i = 64'h0;
    ext_dec_data_i = 64'h0;
    ext_dec_check_i = 8'h00;
    repeat (10) @(posedge clk_i);
    reset_i <= 1'b0;
    @(posedge clk_i);
    test_reset();
    test_shapes();
    test_policy();
    test_fifo();
    test_codec();
    report_and_stop();
  end
  initial begin
    #200000;
    errors++;
    report_and_stop();
  end
endmodule
